// [design/qfd_pkg.sv]
// Shared opcodes, phase codes and cycle counts for the flash command decoder
package qfd_pkg;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h35;
   localparam logic [7:0] OP_LEAVE_QUAD = 8'hF5;
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_FAST       = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
   localparam logic [7:0] OP_QUAD_FIX   = 8'hE7;
   localparam logic [7:0] OP_PP         = 8'h02;
   localparam logic [7:0] OP_QPP        = 8'h38;
   localparam logic [7:0] OP_FACTORY    = 8'h41;
   localparam logic [7:0] OP_SIG        = 8'hAB;
   localparam logic [7:0] OP_CFG_RD     = 8'h15;
   localparam logic [7:0] OP_FSR_RD     = 8'h44;
   localparam logic [7:0] OP_SEC_RD     = 8'h2B;
   localparam logic [7:0] OP_SEC_WR     = 8'h2F;
   localparam logic [7:0] OP_LOCK_WR    = 8'h2C;
   localparam logic [7:0] OP_LOCK_RD    = 8'h2D;
   localparam logic [7:0] OP_RST_ARM    = 8'h66;
   localparam logic [7:0] OP_RST        = 8'h99;
   localparam logic [7:0] OP_UNLOCK     = 8'h06;
   localparam logic [7:0] OP_RELOCK     = 8'h04;
   localparam logic [7:0] OP_NOP        = 8'h00;

   localparam logic [4:0] DUMMY_FAST    = 5'h08;
   localparam logic [4:0] DUMMY_DUAL_IO = 5'h04;
   localparam logic [4:0] DUMMY_QUAD_IO = 5'h06;
   localparam logic [4:0] DUMMY_FIXED   = 5'h04;
   localparam logic [4:0] DUMMY_SIG     = 5'h18;
   localparam logic [4:0] DUMMY_DC_1    = 5'h06;
   localparam logic [4:0] DUMMY_DC_2    = 5'h08;
   localparam logic [4:0] DUMMY_DC_3    = 5'h0A;
   localparam logic [8:0] PAGE_MAX      = 9'h100;
   localparam logic [9:0] BYTES_SAT     = 10'h3FF;
   localparam int         CFG_DC_LOW_BIT  = 6;
   localparam int         CFG_DC_HIGH_BIT = 7;

   typedef enum logic [4:0] {
      PH_CMD   = 5'h01,
      PH_ADDR  = 5'h02,
      PH_DUMMY = 5'h04,
      PH_DATA  = 5'h08,
      PH_SKIP  = 5'h10
   } qfd_phase_e;
endpackage

// [design/qfd_sync2.sv]
// Two-flop synchroniser for levels and quasi-static words
module qfd_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   import qfd_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } qfd_sync_s;

   qfd_sync_s s_reg;
   qfd_sync_s s_next;

   always_comb begin
      s_next.meta = d_in;
      s_next.stab = s_reg.meta;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q_out = s_reg.stab;
endmodule // qfd_sync2

// [design/qfd_cmd_table.sv]
// Opcode table: legality per mode, phase lengths and line widths
module qfd_cmd_table (
   input  wire logic [7:0] op_in,
   input  wire logic       quad_in,
   input  wire logic [1:0] dc_in,
   output logic            known_out,
   output logic            rd_out,
   output logic      [1:0] abytes_out,
   output logic      [1:0] ash_out,
   output logic      [1:0] dsh_out,
   output logic      [4:0] dummy_out,
   output logic      [8:0] wmin_out,
   output logic      [8:0] wmax_out
);
   import qfd_pkg::*;

   logic [1:0] qsh;
   logic [4:0] dcx;

   always_comb begin
      qsh = quad_in ? 2'h2 : 2'h0;
      dcx = (dc_in == 2'h1) ? DUMMY_DC_1 : (dc_in == 2'h2) ? DUMMY_DC_2 : DUMMY_DC_3;
      known_out  = 1'b1;
      rd_out     = 1'b0;
      abytes_out = 2'h0;
      ash_out    = qsh;
      dsh_out    = qsh;
      dummy_out  = 5'h00;
      wmin_out   = 9'h000;
      wmax_out   = 9'h000;
      case (op_in)
         OP_ENTER_QUAD: known_out = !quad_in;
         OP_LEAVE_QUAD: known_out = quad_in;
         OP_READ: begin
            known_out  = !quad_in;
            rd_out     = 1'b1;
            abytes_out = 2'h3;
         end
         OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT: begin
            known_out  = !quad_in;
            rd_out     = 1'b1;
            abytes_out = 2'h3;
            dsh_out    = (op_in == OP_FAST) ? 2'h0 : (op_in == OP_DUAL_OUT) ? 2'h1 : 2'h2;
            dummy_out  = (dc_in == 2'h0) ? DUMMY_FAST : dcx;
         end
         OP_DUAL_IO: begin
            known_out  = !quad_in;
            rd_out     = 1'b1;
            abytes_out = 2'h3;
            ash_out    = 2'h1;
            dsh_out    = 2'h1;
            dummy_out  = (dc_in == 2'h0) ? DUMMY_DUAL_IO : dcx;
         end
         OP_QUAD_IO: begin
            rd_out     = 1'b1;
            abytes_out = 2'h3;
            ash_out    = 2'h2;
            dsh_out    = 2'h2;
            dummy_out  = (dc_in == 2'h0) ? DUMMY_QUAD_IO : dcx;
         end
         OP_QUAD_FIX: begin
            known_out  = !quad_in;
            rd_out     = 1'b1;
            abytes_out = 2'h3;
            ash_out    = 2'h2;
            dsh_out    = 2'h2;
            dummy_out  = DUMMY_FIXED;
         end
         OP_PP: begin
            abytes_out = 2'h3;
            wmin_out   = 9'h001;
            wmax_out   = PAGE_MAX;
         end
         OP_QPP: begin
            known_out  = !quad_in;
            abytes_out = 2'h3;
            ash_out    = 2'h2;
            dsh_out    = 2'h2;
            wmin_out   = 9'h001;
            wmax_out   = PAGE_MAX;
         end
         OP_SIG: begin
            rd_out    = 1'b1;
            dummy_out = DUMMY_SIG;
         end
         OP_CFG_RD, OP_FSR_RD, OP_SEC_RD: rd_out = 1'b1;
         OP_SEC_WR: begin
            wmin_out = 9'h001;
            wmax_out = 9'h001;
         end
         OP_LOCK_WR: begin
            known_out = !quad_in;
            wmin_out  = 9'h002;
            wmax_out  = 9'h002;
         end
         OP_LOCK_RD: begin
            known_out = !quad_in;
            rd_out    = 1'b1;
         end
         OP_FACTORY, OP_RST_ARM, OP_RST, OP_UNLOCK, OP_RELOCK, OP_NOP: known_out = 1'b1;
         default: known_out = 1'b0;
      endcase
   end
endmodule // qfd_cmd_table

// [design/qfd_cmd_decoder.sv]
// Serial flash command decoder: link-side opcode engine and core-side mode state
//
// Behaviour
// - Accepted 35h in single-line mode switches to four-line command mode.
// - Four-line mode carries everything on four lines; quad enable bit untouched.
// - Four-line mode takes command and address on four lines, drives reads on four.
// - Only accepted F5h, legal in four-line mode only, leaves four-line mode.
// - After leaving, opcodes arrive again one bit per clock on one line.
// - Fast, dual and quad reads take dummy count from config bits 6 and 7.
// - E7h: three address bytes, four fixed dummy clocks, streamed data, single mode.
// - BBh: dual address and data, default four dummies, endless data, single mode.
// - 38h quad program: single mode, three address bytes, 1 to 256 bytes.
// - 41h factory enable accepted in both modes, opcode only.
// - ABh in both modes: 24 dummy clocks then the signature byte.
// - 15h in both modes returns one config byte, no address or dummy.
// - 44h in both modes returns one factory status byte.
// - 2Bh in both modes returns one security register byte.
// - 2Fh in both modes takes exactly one data byte, no address.
// - 2Ch single mode only takes two data bytes, no address or dummy.
// - 2Dh single mode only returns two lock bytes.
// - Inputs sampled on rising link clock; outputs change on falling edge.
// - Non-read commands need chip select high on a byte boundary, else rejected.
// - Reset executes only when reset-arm was the immediately preceding command.
// - Accepted 06h sets the write unlock latch.
module qfd_cmd_decoder (
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        link_clk_in,
   input  wire logic        cs_n_in,
   input  wire logic [3:0]  sio_in,
   output logic      [3:0]  sio_out,
   output logic      [3:0]  sio_oe_n_out,
   input  wire logic [7:0]  config_reg_in,
   input  wire logic [7:0]  factory_status_in,
   input  wire logic [7:0]  security_reg_in,
   input  wire logic [15:0] lock_reg_in,
   input  wire logic [7:0]  signature_in,
   input  wire logic [7:0]  array_byte_in,
   output logic             quad_mode_out,
   output logic             write_unlock_latch_out,
   output logic             factory_speedup_out,
   output logic             soft_reset_out,
   output logic             cmd_done_out,
   output logic             cmd_rejected_out,
   output logic      [7:0]  cmd_opcode_out,
   output logic      [23:0] cmd_addr_out,
   output logic      [15:0] cmd_data_out
);
   import qfd_pkg::*;

   typedef struct packed {
      qfd_phase_e  phase;
      logic        quad;
      logic        tog;
      logic [7:0]  op;
      logic [3:0]  bitcnt;
      logic [5:0]  cnt;
      logic [9:0]  bytes;
      logic [23:0] addr;
      logic [15:0] wdata;
   } qfd_link_s;

   typedef struct packed {
      logic [3:0] so;
      logic [3:0] oe_n;
   } qfd_pin_s;

   typedef struct packed {
      logic        cs_prev;
      logic        tog_seen;
      logic        quad;
      logic        write_unlock_latch;
      logic        fact;
      logic        armed;
      logic        done;
      logic        rej;
      logic        srst;
      logic [7:0]  op;
      logic [23:0] addr;
      logic [15:0] data;
   } qfd_core_s;

   qfd_link_s lr, ln, cur;
   qfd_pin_s  pr, pn;
   qfd_core_s cr, cn;
   logic      fresh_reg;

   function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] s,
                                            input logic [1:0] sh);
      case (sh)
         2'h2:    return {v[19:0], s};
         2'h1:    return {v[21:0], s[1:0]};
         default: return {v[22:0], s[0]};
      endcase
   endfunction

   // Register contents are quasi-static; they refresh only while the link clock runs
   logic [55:0] rs;
   logic [7:0]  cfg_s, fsr_s, sec_s, sig_s, arr_s;
   logic [15:0] lock_s;

   qfd_sync2 #(.W(56)) u_link_sync (
      .clk_in  (link_clk_in),
      .nrst_in (nrst_in),
      .d_in    ({config_reg_in, factory_status_in, security_reg_in,
                 lock_reg_in, signature_in, array_byte_in}),
      .q_out   (rs)
   );
   assign {cfg_s, fsr_s, sec_s, lock_s, sig_s, arr_s} = rs;

   // Link domain
   // First-edge flag; cs high is the only frame end the stopped clock can give
   always_ff @(posedge link_clk_in or negedge nrst_in or posedge cs_n_in) begin
      if (!nrst_in || cs_n_in) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   logic       held_clean, enter_done, leave_done;
   logic [7:0] op_shift, tbl_op;
   logic       t_known, t_rd;
   logic [1:0] t_ab, t_ash, t_dsh;
   logic [4:0] t_dum, addr_cyc;
   logic [8:0] t_wmin, t_wmax;
   logic [3:0] nbit;

   // Mode switches of the previous frame are applied at the next frame's first edge
   assign held_clean = lr.phase == PH_DATA && lr.bitcnt == 4'h0 && lr.bytes == 10'h000;
   assign enter_done = lr.op == OP_ENTER_QUAD && held_clean;
   assign leave_done = lr.op == OP_LEAVE_QUAD && held_clean;
   assign op_shift   = cur.quad ? {cur.op[3:0], sio_in} : {cur.op[6:0], sio_in[0]};
   assign tbl_op     = (cur.phase == PH_CMD) ? op_shift : cur.op;

   qfd_cmd_table u_link_tbl (
      .op_in      (tbl_op),
      .quad_in    (cur.quad),
      .dc_in      ({cfg_s[CFG_DC_HIGH_BIT], cfg_s[CFG_DC_LOW_BIT]}),
      .known_out  (t_known),
      .rd_out     (t_rd),
      .abytes_out (t_ab),
      .ash_out    (t_ash),
      .dsh_out    (t_dsh),
      .dummy_out  (t_dum),
      .wmin_out   (t_wmin),
      .wmax_out   (t_wmax)
   );

   assign addr_cyc = 5'({t_ab, 3'b000} >> t_ash);

   always_comb begin
      cur = lr;
      if (fresh_reg) begin
         cur.quad   = lr.quad ? !leave_done : enter_done;
         cur.phase  = PH_CMD;
         cur.tog    = !lr.tog;
         cur.op     = 8'h00;
         cur.bitcnt = 4'h0;
         cur.cnt    = 6'h00;
         cur.bytes  = 10'h000;
         cur.addr   = 24'h00_0000;
         cur.wdata  = 16'h0000;
      end
      ln   = cur;
      nbit = cur.bitcnt + (4'h1 << t_dsh);
      unique case (cur.phase)
         PH_CMD: begin
            ln.op     = op_shift;
            ln.bitcnt = cur.bitcnt + (cur.quad ? 4'h4 : 4'h1);
            if (ln.bitcnt == 4'h8) begin
               ln.bitcnt = 4'h0;
               if (!t_known) begin
                  ln.phase = PH_SKIP;
               end else if (t_ab != 2'h0) begin
                  ln.phase = PH_ADDR;
                  ln.cnt   = {1'b0, addr_cyc - 5'h01};
               end else if (t_dum != 5'h00) begin
                  ln.phase = PH_DUMMY;
                  ln.cnt   = {1'b0, t_dum - 5'h01};
               end else begin
                  ln.phase = PH_DATA;
               end
            end
         end
         PH_ADDR: begin
            ln.addr = shift_in(cur.addr, sio_in, t_ash);
            if (cur.cnt != 6'h00) begin
               ln.cnt = cur.cnt - 6'h01;
            end else if (t_dum != 5'h00) begin
               ln.phase = PH_DUMMY;
               ln.cnt   = {1'b0, t_dum - 5'h01};
            end else begin
               ln.phase = PH_DATA;
            end
         end
         PH_DUMMY: begin
            if (cur.cnt != 6'h00) begin
               ln.cnt = cur.cnt - 6'h01;
            end else begin
               ln.phase = PH_DATA;
            end
         end
         PH_DATA: begin
            if (nbit[3]) begin
               ln.bitcnt = 4'h0;
               ln.bytes  = (cur.bytes == BYTES_SAT) ? cur.bytes : cur.bytes + 10'h001;
            end else begin
               ln.bitcnt = nbit;
            end
            if (!t_rd && cur.bytes < 10'h002) begin
               ln.wdata = 16'(shift_in({8'h00, cur.wdata}, sio_in, t_dsh));
            end
         end
         PH_SKIP: ln.phase = PH_SKIP;
         default: ln.phase = PH_SKIP;
      endcase
   end

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lr <= '{phase: PH_CMD, default: '0};
      end else begin
         lr <= ln;
      end
   end

   // Output path: falling-edge update, released whenever chip select is high
   logic [7:0] rbyte, rshift;
   logic       drive;

   always_comb begin
      case (lr.op)
         OP_CFG_RD:  rbyte = cfg_s;
         OP_FSR_RD:  rbyte = fsr_s;
         OP_SEC_RD:  rbyte = sec_s;
         OP_SIG:     rbyte = sig_s;
         OP_LOCK_RD: rbyte = lr.bytes[0] ? lock_s[7:0] : lock_s[15:8];
         default:    rbyte = arr_s;
      endcase
      rshift  = 8'(rbyte << lr.bitcnt);
      drive   = cur.phase == PH_DATA && t_rd;
      pn.so   = 4'h0;
      pn.oe_n = 4'hF;
      if (drive) begin
         case (t_dsh)
            2'h2: begin
               pn.so   = rshift[7:4];
               pn.oe_n = 4'h0;
            end
            2'h1: begin
               pn.so   = {2'b00, rshift[7:6]};
               pn.oe_n = 4'hC;
            end
            default: begin
               pn.so   = {2'b00, rshift[7], 1'b0};
               pn.oe_n = 4'hD;
            end
         endcase
      end
   end

   always_ff @(negedge link_clk_in or negedge nrst_in or posedge cs_n_in) begin
      if (!nrst_in || cs_n_in) begin
         pr <= '{so: 4'h0, oe_n: 4'hF};
      end else begin
         pr <= pn;
      end
   end

   assign sio_out      = pr.so;
   assign sio_oe_n_out = pr.oe_n;

   // Core domain
   logic [1:0] cs_tog_s;
   logic       c_known, c_rd, eval, ok;
   logic [8:0] c_wmin, c_wmax;

   qfd_sync2 #(.W(2)) u_core_sync (
      .clk_in  (core_clk_in),
      .nrst_in (nrst_in),
      .d_in    ({cs_n_in, lr.tog}),
      .q_out   (cs_tog_s)
   );

   // Link fields are frozen once chip select is high, so they are read directly here
   qfd_cmd_table u_core_tbl (
      .op_in      (lr.op),
      .quad_in    (cr.quad),
      .dc_in      ({config_reg_in[CFG_DC_HIGH_BIT], config_reg_in[CFG_DC_LOW_BIT]}),
      .known_out  (c_known),
      .rd_out     (c_rd),
      .abytes_out (),
      .ash_out    (),
      .dsh_out    (),
      .dummy_out  (),
      .wmin_out   (c_wmin),
      .wmax_out   (c_wmax)
   );

   // Frame toggle tells a clocked frame from an empty chip-select pulse
   // An empty pulse leaves the toggle as last seen, so a frame is never judged twice
   assign eval = cs_tog_s[1] && !cr.cs_prev && cs_tog_s[0] == lr.tog && lr.tog != cr.tog_seen
                 && lr.phase != PH_CMD;
   assign ok   = c_known && lr.phase == PH_DATA && (c_rd || (lr.bitcnt == 4'h0
                 && lr.bytes >= {1'b0, c_wmin} && lr.bytes <= {1'b0, c_wmax}));

   always_comb begin
      cn         = cr;
      cn.cs_prev = cs_tog_s[1];
      cn.done    = 1'b0;
      cn.rej     = 1'b0;
      cn.srst    = 1'b0;
      if (eval) begin
         cn.tog_seen = lr.tog;
         cn.op    = lr.op;
         cn.addr  = lr.addr;
         cn.data  = lr.wdata;
         cn.done  = ok;
         cn.rej   = !ok;
         cn.armed = ok && lr.op == OP_RST_ARM;
         if (ok) begin
            unique case (lr.op)
               OP_ENTER_QUAD: cn.quad = 1'b1;
               OP_LEAVE_QUAD: cn.quad = 1'b0;
               OP_UNLOCK:     cn.write_unlock_latch  = 1'b1;
               OP_FACTORY:    cn.fact = 1'b1;
               OP_RELOCK, OP_SEC_WR, OP_LOCK_WR: cn.write_unlock_latch = 1'b0;
               OP_QPP, OP_PP: begin
                  cn.write_unlock_latch  = 1'b0;
                  cn.fact = 1'b0;
               end
               OP_RST: begin
                  cn.srst = cr.armed;
                  cn.write_unlock_latch  = cr.armed ? 1'b0 : cr.write_unlock_latch;
                  cn.fact = cr.armed ? 1'b0 : cr.fact;
               end
               default: cn.write_unlock_latch = cr.write_unlock_latch;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cr <= '0;
      end else begin
         cr <= cn;
      end
   end

   assign quad_mode_out          = cr.quad;
   assign write_unlock_latch_out = cr.write_unlock_latch;
   assign factory_speedup_out    = cr.fact;
   assign soft_reset_out         = cr.srst;
   assign cmd_done_out           = cr.done;
   assign cmd_rejected_out       = cr.rej;
   assign cmd_opcode_out         = cr.op;
   assign cmd_addr_out           = cr.addr;
   assign cmd_data_out           = cr.data;

   // Checks
   logic link_off;
   assign link_off = !nrst_in || cs_n_in;

   sequence s_single_op;
      (lr.phase == PH_CMD) [*7] ##1 (lr.phase != PH_CMD);
   endsequence
   sequence s_quad_op;
      (lr.phase == PH_CMD) ##1 (lr.phase != PH_CMD);
   endsequence

   a_single_opcode: assert property (@(posedge link_clk_in) disable iff (link_off)
      fresh_reg && !cur.quad |=> s_single_op) else $error("single opcode not 8 clocks");
   a_quad_opcode: assert property (@(posedge link_clk_in) disable iff (link_off)
      fresh_reg && cur.quad |=> s_quad_op) else $error("quad opcode not 2 clocks");
   a_skip_hold: assert property (@(posedge link_clk_in) disable iff (link_off)
      lr.phase == PH_SKIP && !fresh_reg |=> lr.phase == PH_SKIP)
      else $error("ignored frame resumed");
   a_fixed_dummy: assert property (@(posedge link_clk_in) disable iff (link_off)
      $rose(lr.phase == PH_DUMMY) && lr.op == OP_QUAD_FIX
      |-> (lr.phase == PH_DUMMY) [*4] ##1 lr.phase == PH_DATA) else $error("E7 dummy not 4");
   a_sig_dummy: assert property (@(posedge link_clk_in) disable iff (link_off)
      $rose(lr.phase == PH_DUMMY) && lr.op == OP_SIG
      |-> ##23 lr.phase == PH_DUMMY ##1 lr.phase == PH_DATA) else $error("AB dummy not 24");
   a_quad_drive: assert property (@(negedge link_clk_in) disable iff (link_off)
      (drive && lr.quad) ##1 drive |-> sio_oe_n_out == 4'h0) else $error("quad read not driven");
   a_enter_quad: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      eval && ok && lr.op == OP_ENTER_QUAD |=> quad_mode_out && cmd_done_out)
      else $error("quad mode not entered");
   a_leave_quad: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      $fell(quad_mode_out) |-> $past(lr.op) == OP_LEAVE_QUAD && $past(eval) && $past(ok))
      else $error("quad mode left without exit");
   a_wel_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      eval && ok && lr.op == OP_UNLOCK |=> write_unlock_latch_out)
      else $error("unlock latch not set");
   a_reset_pair: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      soft_reset_out |-> $past(cr.armed) && cmd_opcode_out == OP_RST)
      else $error("reset without arm");
   a_boundary_rej: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      eval && !c_rd && lr.bitcnt != 4'h0 |=> cmd_rejected_out && !cmd_done_out)
      else $error("misaligned write accepted");
endmodule // qfd_cmd_decoder

// [testbench/qfd_host.sv]
// Host serial controller model for the flash link
module qfd_host (
   output logic            clk_out,
   output logic            cs_n_out,
   output logic      [3:0] sio_out,
   input  wire logic [3:0] line_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      clk_out = 1'b0;
      cs_n_out = 1'b1;
      sio_out = 4'h5;
   end
   // Edges during reset only; the clock stands still between frames
   task automatic tick(input int n);
      repeat (2 * n) #32 clk_out = ~clk_out;
   endtask
   task automatic sh(input int wi, input int wo, input int n, inout logic [63:0] s,
                     inout logic [15:0] rd);
      repeat (n) begin
         case (wi)
            4: sio_out = s[63:60];
            2: sio_out = {~sio_out[3:2], s[63:62]};
            1: sio_out = {~sio_out[3:1], s[63]};
            default: sio_out = ~sio_out;
         endcase
         s = s << wi;
         #32;
         case (wo)
            4: rd = {rd[11:0], line_in};
            2: rd = {rd[13:0], line_in[1:0]};
            default: rd = {rd[14:0], line_in[1]};
         endcase
         clk_out = 1'b1;
         #32 clk_out = 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] op, input bit q, input int wi, input int n,
                        input logic [63:0] tx, input int wo, input int nr,
                        output logic [15:0] rd);
      logic [63:0] s;
      s = {op, 56'h0};
      rd = 16'h0000;
      cs_n_out = 1'b0;
      #16;
      sh(q ? 4 : 1, 0, q ? 2 : 8, s, rd);
      sh(wi, 0, n, tx, rd);
      rd = 16'h0000;
      sh(0, wo, nr, s, rd);
      #16 cs_n_out = 1'b1;
      sio_out = ~sio_out;
      #800;
   endtask
endmodule // qfd_host

// [testbench/tb_qfd_cmd_decoder.sv]
// Self-checking bench for the serial flash command decoder
module tb_qfd_cmd_decoder;
   import qfd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        lclk, cs_n, quad, wul, fsp, srst, done, rej;
   logic [3:0]  hs, ds, oe_n, line;
   logic [7:0]  cfg = 8'h1A;
   logic [7:0]  arr = 8'h96;
   logic [7:0]  op_seen;
   logic [7:0]  bad [4] = '{OP_QUAD_FIX, OP_QPP, OP_LOCK_RD, OP_LOCK_WR};
   logic [15:0] rd, dat;
   logic [23:0] adr;
   int          fail_count, compares, n_rej, n_rst, cyc, k;
   assign line = (~oe_n & ds) | (oe_n & hs);
   always #50 clk = ~clk;
   qfd_host u_qfd_host (.clk_out(lclk), .cs_n_out(cs_n), .sio_out(hs), .line_in(line));
   // Signature value is arbitrary
   qfd_cmd_decoder u_qfd_cmd_decoder (.core_clk_in(clk), .nrst_in(nrst), .link_clk_in(lclk),
      .cs_n_in(cs_n), .sio_in(line), .sio_out(ds), .sio_oe_n_out(oe_n), .config_reg_in(cfg),
      .factory_status_in(8'h3C), .security_reg_in(8'hC5), .lock_reg_in(16'h71E4),
      .signature_in(8'hA7), .array_byte_in(arr), .quad_mode_out(quad),
      .write_unlock_latch_out(wul), .factory_speedup_out(fsp), .soft_reset_out(srst),
      .cmd_done_out(done), .cmd_rejected_out(rej), .cmd_opcode_out(op_seen),
      .cmd_addr_out(adr), .cmd_data_out(dat));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic f(input logic [7:0] op, input bit q, input int wi, input int n,
                    input logic [63:0] tx, input int wo, input int nr);
      u_qfd_host.frame(op, q, wi, n, tx, wo, nr, rd);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_rej <= n_rej + int'(rej === 1'b1);
      n_rst <= n_rst + int'(srst === 1'b1);
      if (cyc == 5000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      fork
         u_qfd_host.tick(8);
         repeat (8) @(posedge clk);
      join
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk(oe_n, 4'hF);
      f(OP_CFG_RD, 0, 1, 0, 0, 1, 8);
      chk(rd[7:0], 8'h1A);
      f(OP_DUAL_IO, 0, 2, 16, {24'h12_3456, 40'h0}, 2, 4);
      chk(rd[7:0], 8'h96);
      f(OP_QUAD_FIX, 0, 4, 10, {24'h12_3456, 40'h0}, 4, 2);
      chk(rd[7:0], 8'h96);
      chk(adr, 24'h12_3456);
      @(posedge clk) cfg <= 8'h5A;
      arr <= 8'h69;
      f(OP_FAST, 0, 1, 30, {24'h00_0010, 40'h0}, 1, 8);
      chk(rd[7:0], 8'h69);
      f(OP_SIG, 0, 1, 24, 0, 1, 8);
      chk(rd[7:0], 8'hA7);
      f(OP_LOCK_RD, 0, 1, 0, 0, 1, 16);
      chk(rd, 16'h71E4);
      f(OP_UNLOCK, 0, 1, 0, 0, 0, 0);
      chk(wul, 1'b1);
      f(OP_RST_ARM, 0, 1, 0, 0, 0, 0);
      f(OP_RST, 0, 1, 0, 0, 0, 0);
      f(OP_RST_ARM, 0, 1, 0, 0, 0, 0);
      f(OP_NOP, 0, 1, 0, 0, 0, 0);
      f(OP_RST, 0, 1, 0, 0, 0, 0);
      chk(24'(n_rst), 24'h00_0001);
      k = n_rej;
      f(OP_UNLOCK, 0, 1, 3, 0, 0, 0);
      chk(24'(n_rej - k), 24'h00_0001);
      chk(wul, 1'b0);
      f(OP_LOCK_WR, 0, 1, 16, {16'hBEEF, 48'h0}, 0, 0);
      chk(dat, 16'hBEEF);
      f(OP_SEC_WR, 0, 1, 8, {8'h5C, 56'h0}, 0, 0);
      chk(dat[7:0], 8'h5C);
      f(OP_QPP, 0, 4, 8, {24'hAB_CDEF, 8'h3C, 32'h0000_0000}, 0, 0);
      chk(adr, 24'hAB_CDEF);
      chk(dat[7:0], 8'h3C);
      f(OP_FACTORY, 0, 1, 0, 0, 0, 0);
      chk(fsp, 1'b1);
      f(OP_ENTER_QUAD, 0, 1, 0, 0, 0, 0);
      chk(quad, 1'b1);
      f(OP_CFG_RD, 1, 4, 0, 0, 4, 2);
      chk(rd[7:0], 8'h5A);
      f(OP_FSR_RD, 1, 4, 0, 0, 4, 2);
      chk(rd[7:0], 8'h3C);
      f(OP_SEC_RD, 1, 4, 0, 0, 4, 2);
      chk(rd[7:0], 8'hC5);
      k = n_rej;
      // Extra clocks after each refused opcode keep the ignored state in view
      foreach (bad[i]) f(bad[i], 1, 0, 0, 0, 4, 2);
      chk(24'(n_rej - k), 24'h00_0004);
      chk(quad, 1'b1);
      f(OP_LEAVE_QUAD, 1, 4, 0, 0, 0, 0);
      chk(quad, 1'b0);
      f(OP_SEC_RD, 0, 1, 0, 0, 1, 8);
      chk(rd[7:0], 8'hC5);
      results();
   end
endmodule // tb_qfd_cmd_decoder
